/* lpm_defs.svh */
// offsets, field positions, reset values and counts of the pixel format and pin map block
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

`define LPM_OFF_CTRL 12'h000
`define LPM_OFF_HTIM 12'h004
`define LPM_OFF_VTIM 12'h008
`define LPM_OFF_SPOS 12'h00C
`define LPM_OFF_SPOL 12'h010
`define LPM_OFF_STAT 12'h014
`define LPM_OFF_PLOAD 12'h018

`define LPM_CTRL_RST 32'h0000_0000
`define LPM_HTIM_RST 32'h0004_0020
`define LPM_VTIM_RST 32'h0010_000F
`define LPM_SPOS_RST 32'h0000_0000
`define LPM_SPOL_RST 32'h0000_000F

`define LPM_PAL_WORDS_8 8'd128
`define LPM_PAL_WORDS_4 8'd8
`define LPM_PAL_WORDS_2 8'd2
`define LPM_PAL_WORDS_1 8'd1

`define LPM_SIG_CLS 0
`define LPM_SIG_REV 1
`define LPM_SIG_SPL 2
`define LPM_SIG_PWR 3

`endif

/* lpm_pkg.sv */
// types of the pixel format and pin map block
package lpm_pkg;

	typedef enum logic [1:0] {
		LPM_IDLE = 2'b00,
		LPM_NULL = 2'b01,
		LPM_RUN = 2'b10
	} lpm_phase_t;

	typedef enum logic [2:0] {
		LPM_BPP1 = 3'b000,
		LPM_BPP2 = 3'b001,
		LPM_BPP4 = 3'b010,
		LPM_IDX8 = 3'b011,
		LPM_BPP16 = 3'b100,
		LPM_BPP18 = 3'b101,
		LPM_BPP24 = 3'b110,
		LPM_BPP16A = 3'b111
	} lpm_bpp_t;

	typedef struct packed {
		logic [16:0] unused;
		logic delta;
		logic [1:0] spec_mode;
		logic pclk_pol;
		logic hs_pol;
		logic vs_pol;
		logic [1:0] panel_data_width_select;
		logic dual;
		logic tft;
		logic stn_565_555_select;
		lpm_bpp_t bpp;
		logic enable;
	} lpm_ctrl_t;

	typedef struct packed {
		logic [17:0] dat;
		logic [5:0] lo6;
		logic [7:0] alpha;
		logic [3:0] spec;
		logic vsync;
		logic hsync;
		logic de;
		logic pclk;
	} lpm_pins_t;

	typedef struct packed {
		lpm_ctrl_t ctrl;
		logic [11:0] htotal;
		logic [7:0] hsync_w;
		logic [11:0] vdisp;
		logic [11:0] vtotal;
		logic [31:0] spos;
		logic [3:0] spol;
		logic [2:0] odd_order;
		logic [2:0] even_order;
		lpm_phase_t phase;
		logic [11:0] hcnt;
		logic [11:0] vcnt;
		logic [3:0] tog;
		logic [2:0] pclk_sync;
		lpm_pins_t pins;
		logic pix_take;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic dma0_req;
		logic [7:0] pal_left;
		logic [6:0] pal_idx;
		logic pal_loaded;
	} lpm_state_t;

endpackage : lpm_pkg

/* lpm_pixel_pin_map.sv */
// pixel formatting, palette, special tft signals and panel pin mapping with an apb register file
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "lpm_defs.svh"

module lpm_pixel_pin_map
	import lpm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lcd_pclk_in,
	input wire logic [31:0] pix_word,
	input wire logic [7:0] lower_panel_word,
	output logic pix_take,
	output logic dma0_req,
	input wire logic dma0_ack,
	input wire logic [31:0] dma0_data,
	output logic [17:0] lcd_dat,
	output logic [5:0] lcd_lo6,
	output logic [7:0] lcd_alpha,
	output logic lcd_vsync,
	output logic lcd_hsync,
	output logic lcd_de,
	output logic lcd_pclk_out,
	output logic lcd_cls,
	output logic lcd_rev,
	output logic lcd_spl,
	output logic power_save_signal
);

	lpm_state_t st_reg;
	lpm_state_t st_next;
	logic [15:0] pal_mem [0:255];
	logic [3:0] spec_hit;
	logic [3:0] spec_toggle_mode;
	logic [3:0] spec_level;

	// expand a 16 bit pixel into left aligned 8 bit channels
	function automatic logic [23:0] dec16(input logic [15:0] e, input logic is555);
		logic [23:0] r;
		r = 24'h00_0000;
		if (is555)
		begin
			r = {e[14:10], e[14:12], e[9:5], e[9:7], e[4:0], e[4:2]};
		end
		else
		begin
			r = {e[15:11], e[15:13], e[10:5], e[10:9], e[4:0], e[4:2]};
		end
		return r;
	endfunction : dec16

	// reorder colour channels for delta panels
	function automatic logic [23:0] perm(input logic [2:0] ord, input logic [23:0] c);
		logic [23:0] r;
		r = c;
		case (ord)
			3'd1: r = {c[23:16], c[7:0], c[15:8]};
			3'd2: r = {c[15:8], c[23:16], c[7:0]};
			3'd3: r = {c[15:8], c[7:0], c[23:16]};
			3'd4: r = {c[7:0], c[23:16], c[15:8]};
			3'd5: r = {c[7:0], c[15:8], c[23:16]};
			default: r = c;
		endcase
		return r;
	endfunction : perm

	// per signal: match of the programmed position and working mode
	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_spec
			assign spec_hit[i] = (st_reg.hcnt == {4'h0, st_reg.spos[i*8 +: 8]});
			assign spec_level[i] = (spec_toggle_mode[i] ? st_reg.tog[i] : spec_hit[i])
				^ ~st_reg.spol[i];
		end
	endgenerate

	// column latch pulses, reversal toggles, the other two follow the mode
	always_comb
	begin
		spec_toggle_mode = 4'h0;
		spec_toggle_mode[`LPM_SIG_CLS] = 1'b0;
		spec_toggle_mode[`LPM_SIG_REV] = 1'b1;
		spec_toggle_mode[`LPM_SIG_SPL] = (st_reg.ctrl.spec_mode == 2'd3);
		spec_toggle_mode[`LPM_SIG_PWR] = (st_reg.ctrl.spec_mode >= 2'd2);
	end

	// next state of the whole block
	always_comb
	begin
		logic wr;
		logic rd;
		logic edge_seen;
		logic line_end;
		logic disp_line;
		logic de_now;
		logic [7:0] idx;
		logic [23:0] rgb;
		logic [7:0] up;
		logic [7:0] lo;
		logic [7:0] words;
		wr = 1'b0;
		rd = 1'b0;
		edge_seen = 1'b0;
		line_end = 1'b0;
		disp_line = 1'b0;
		de_now = 1'b0;
		idx = 8'h00;
		rgb = 24'h00_0000;
		up = 8'h00;
		lo = 8'h00;
		words = 8'h00;
		st_next = st_reg;

		// apb slave, answer in the first access cycle
		st_next.pready = psel & ~penable & ~st_reg.pready;
		st_next.pslverr = 1'b0;
		wr = psel & ~penable & pwrite;
		rd = psel & ~penable & ~pwrite;
		if (psel & ~penable)
		begin
			st_next.prdata = 32'h0000_0000;
			case (paddr)
				`LPM_OFF_CTRL: st_next.prdata = {16'h0000, st_reg.ctrl[15:0]};
				`LPM_OFF_HTIM: st_next.prdata = {8'h00, st_reg.hsync_w, 4'h0, st_reg.htotal};
				`LPM_OFF_VTIM: st_next.prdata = {4'h0, st_reg.vtotal, 4'h0, st_reg.vdisp};
				`LPM_OFF_SPOS: st_next.prdata = st_reg.spos;
				`LPM_OFF_SPOL: st_next.prdata = {20'h0_0000, 1'b0, st_reg.even_order,
					1'b0, st_reg.odd_order, st_reg.spol};
				`LPM_OFF_STAT: st_next.prdata = {8'h00, st_reg.tog, st_reg.pal_loaded,
					st_reg.dma0_req, st_reg.phase, 4'h0, st_reg.vcnt};
				`LPM_OFF_PLOAD: st_next.prdata = 32'h0000_0000;
				default: st_next.pslverr = 1'b1;
			endcase
			if (rd)
			begin
				st_next.pslverr = st_next.pslverr;
			end
		end
		// palette fetch over dma channel 0, one word per acknowledge;
		// a new load written in the same cycle as the last word wins below
		if (st_reg.dma0_req && dma0_ack)
		begin
			st_next.pal_idx = st_reg.pal_idx + 7'd1;
			st_next.pal_left = st_reg.pal_left - 8'd1;
			if (st_reg.pal_left == 8'd1)
			begin
				st_next.dma0_req = 1'b0;
				st_next.pal_loaded = 1'b1;
			end
		end
		if (wr)
		begin
			case (paddr)
				`LPM_OFF_CTRL: st_next.ctrl = {16'h0000, pwdata[15:0]};
				`LPM_OFF_HTIM:
				begin
					st_next.htotal = pwdata[11:0];
					st_next.hsync_w = pwdata[23:16];
				end
				`LPM_OFF_VTIM:
				begin
					st_next.vdisp = pwdata[11:0];
					st_next.vtotal = pwdata[27:16];
				end
				`LPM_OFF_SPOS: st_next.spos = pwdata;
				`LPM_OFF_SPOL:
				begin
					st_next.spol = pwdata[3:0];
					st_next.odd_order = pwdata[6:4];
					st_next.even_order = pwdata[10:8];
				end
				`LPM_OFF_PLOAD:
				begin
					case (st_reg.ctrl.bpp)
						LPM_IDX8: words = `LPM_PAL_WORDS_8;
						LPM_BPP4: words = `LPM_PAL_WORDS_4;
						LPM_BPP2: words = `LPM_PAL_WORDS_2;
						LPM_BPP1: words = `LPM_PAL_WORDS_1;
						default: words = 8'h00;
					endcase
					if (pwdata[0] && words != 8'h00)
					begin
						st_next.pal_left = words;
						st_next.pal_idx = 7'h00;
						st_next.dma0_req = 1'b1;
						st_next.pal_loaded = 1'b0;
					end
				end
				default: st_next.ctrl = st_reg.ctrl;
			endcase
		end

		// pixel clock synchroniser and rising edge
		st_next.pclk_sync = {st_reg.pclk_sync[1:0], lcd_pclk_in};
		edge_seen = st_reg.pclk_sync[1] & ~st_reg.pclk_sync[2];
		st_next.pix_take = 1'b0;
		st_next.pins.pclk = st_reg.pclk_sync[1] ^ st_reg.ctrl.pclk_pol;

		// enable and disable of the timing
		if (!st_reg.ctrl.enable)
		begin
			st_next.phase = LPM_IDLE;
		end
		else if (st_reg.phase == LPM_IDLE)
		begin
			st_next.phase = LPM_NULL;
			st_next.hcnt = 12'h000;
			st_next.vcnt = 12'h000;
			st_next.tog = 4'h0;
		end

		disp_line = (st_reg.phase == LPM_RUN) && (st_reg.vcnt < st_reg.vdisp);
		line_end = (st_reg.hcnt >= st_reg.htotal);
		de_now = disp_line && (st_reg.hcnt >= {4'h0, st_reg.hsync_w}) && !line_end;

		if (edge_seen && st_reg.phase != LPM_IDLE && st_reg.ctrl.enable)
		begin
			// position counters, the null line sends no pixels
			st_next.hcnt = line_end ? 12'h000 : st_reg.hcnt + 12'd1;
			if (line_end)
			begin
				if (st_reg.phase == LPM_NULL)
				begin
					st_next.phase = LPM_RUN;
					st_next.vcnt = 12'h000;
				end
				else
				begin
					st_next.vcnt = (st_reg.vcnt + 12'd1 >= st_reg.vtotal) ? 12'h000
						: st_reg.vcnt + 12'd1;
				end
			end
			// toggles once per line, SPL only on display lines; frame parity gives the frame start inversion
			for (int i = 0; i < 4; i++)
			begin
				if (spec_toggle_mode[i] && spec_hit[i])
				begin
					if (i != `LPM_SIG_SPL || disp_line)
					begin
						st_next.tog[i] = ~st_reg.tog[i];
					end
				end
			end
			st_next.pins.spec = spec_level;
			st_next.pins.hsync = (st_reg.hcnt < {4'h0, st_reg.hsync_w})
				^ ~st_reg.ctrl.hs_pol;
			st_next.pins.vsync = ((st_reg.phase == LPM_RUN) && (st_reg.vcnt == 12'h000))
				^ ~st_reg.ctrl.vs_pol;
			st_next.pins.de = de_now;
			st_next.pix_take = de_now;

			// colour decode of the frame word
			case (st_reg.ctrl.bpp)
				LPM_BPP1: idx = {7'h00, pix_word[0]};
				LPM_BPP2: idx = {6'h00, pix_word[1:0]};
				LPM_BPP4: idx = {4'h0, pix_word[3:0]};
				default: idx = pix_word[7:0];
			endcase
			case (st_reg.ctrl.bpp)
				LPM_BPP16: rgb = dec16(pix_word[15:0],
					st_reg.ctrl.stn_565_555_select & ~st_reg.ctrl.tft);
				LPM_BPP18: rgb = {pix_word[23:18], 2'b00, pix_word[15:10], 2'b00,
					pix_word[7:2], 2'b00};
				LPM_BPP24: rgb = pix_word[23:0];
				LPM_BPP16A: rgb = dec16(pix_word[15:0], 1'b0);
				default: rgb = dec16(pal_mem[idx],
					st_reg.ctrl.stn_565_555_select & ~st_reg.ctrl.tft);
			endcase
			st_next.pins.alpha = (st_reg.ctrl.bpp == LPM_BPP16A) ? pix_word[31:24]
				: 8'h00;
			if (st_reg.ctrl.delta)
			begin
				rgb = perm(st_reg.vcnt[0] ? st_reg.odd_order : st_reg.even_order, rgb);
			end

			// pin mapping
			up = pix_word[7:0];
			lo = lower_panel_word;
			st_next.pins.dat = 18'h0_0000;
			st_next.pins.lo6 = 6'h00;
			if (!de_now)
			begin
				st_next.pins.dat = 18'h0_0000;
			end
			else if (st_reg.ctrl.tft)
			begin
				st_next.pins.dat = {rgb[23:18], rgb[15:10], rgb[7:2]};
				st_next.pins.lo6 = {rgb[17:16], rgb[9:8], rgb[1:0]};
			end
			else if (st_reg.ctrl.dual)
			begin
				if (st_reg.ctrl.panel_data_width_select == 2'd3)
				begin
					st_next.pins.dat = {2'b00, up, lo};
				end
				else if (st_reg.ctrl.panel_data_width_select == 2'd2)
				begin
					st_next.pins.dat = {6'h00, up[3:0], 4'h0, lo[3:0]};
				end
				else
				begin
					st_next.pins.dat = 18'h0_0000;
				end
			end
			else
			begin
				case (st_reg.ctrl.panel_data_width_select)
					2'd0: st_next.pins.dat = {17'h0_0000, up[0]};
					2'd1: st_next.pins.dat = {16'h0000, up[1:0]};
					2'd2: st_next.pins.dat = {14'h0000, up[3:0]};
					default: st_next.pins.dat = {10'h000, up};
				endcase
			end
		end
		else if (st_reg.phase == LPM_IDLE)
		begin
			// idle pins except alpha and the pixel clock rest at their inactive levels
			st_next.pins.dat = 18'h0_0000;
			st_next.pins.lo6 = 6'h00;
			st_next.pins.de = 1'b0;
			st_next.pins.hsync = ~st_reg.ctrl.hs_pol;
			st_next.pins.vsync = ~st_reg.ctrl.vs_pol;
			st_next.pins.spec = ~st_reg.spol;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= '0;
			st_reg.ctrl <= `LPM_CTRL_RST;
			st_reg.htotal <= 12'(`LPM_HTIM_RST);
			st_reg.hsync_w <= 8'(`LPM_HTIM_RST >> 16);
			st_reg.vdisp <= 12'(`LPM_VTIM_RST);
			st_reg.vtotal <= 12'(`LPM_VTIM_RST >> 16);
			st_reg.spos <= `LPM_SPOS_RST;
			st_reg.spol <= 4'(`LPM_SPOL_RST);
			st_reg.phase <= LPM_IDLE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// palette ram, two entries per dma word
	always_ff @(posedge pclk)
	begin
		if (st_reg.dma0_req && dma0_ack)
		begin
			pal_mem[{st_reg.pal_idx, 1'b0}] <= dma0_data[15:0];
			pal_mem[{st_reg.pal_idx, 1'b1}] <= dma0_data[31:16];
		end
	end

	// outputs straight from the state register
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign pix_take = st_reg.pix_take;
	assign dma0_req = st_reg.dma0_req;
	assign lcd_dat = st_reg.pins.dat;
	assign lcd_lo6 = st_reg.pins.lo6;
	assign lcd_alpha = st_reg.pins.alpha;
	assign lcd_vsync = st_reg.pins.vsync;
	assign lcd_hsync = st_reg.pins.hsync;
	assign lcd_de = st_reg.pins.de;
	assign lcd_pclk_out = st_reg.pins.pclk;
	assign lcd_cls = st_reg.pins.spec[`LPM_SIG_CLS];
	assign lcd_rev = st_reg.pins.spec[`LPM_SIG_REV];
	assign lcd_spl = st_reg.pins.spec[`LPM_SIG_SPL];
	assign power_save_signal = st_reg.pins.spec[`LPM_SIG_PWR];

endmodule : lpm_pixel_pin_map

/* lpm_pixel_pin_map_sva.sv */
// port checker of the pixel pin map block
`timescale 1ns/1ps
`include "lpm_defs.svh"
module lpm_pixel_pin_map_sva
	import lpm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pix_take,
	input wire logic lcd_de,
	input wire logic dma0_req,
	input wire logic dma0_ack,
	input wire logic lcd_cls
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// a write transfer aimed at the palette load register
	logic ld_wr;
	assign ld_wr = psel && pwrite && (paddr == `LPM_OFF_PLOAD);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
	a_dma_start_cause: assert property ($rose(dma0_req) |-> $past(ld_wr) || $past(ld_wr, 2))
		else $error("palette fetch without load");
	a_dma_end_ack: assert property ($fell(dma0_req) |-> $past(dma0_ack))
		else $error("palette fetch ended without a word");
	a_take_single: assert property (pix_take |=> !pix_take [*4])
		else $error("word taken twice in one pixel");
	a_take_in_de: assert property (pix_take |-> lcd_de)
		else $error("word taken outside active data");
	a_cls_pulse_ends: assert property ($rose(lcd_cls) |-> ##[1:12] !lcd_cls)
		else $error("latch strobe did not end");
	// main scenarios
	cover property (dma0_ack);
	cover property (pix_take);
	cover property ($rose(lcd_cls));
endmodule : lpm_pixel_pin_map_sva

bind lpm_pixel_pin_map lpm_pixel_pin_map_sva chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .pix_take(pix_take), .lcd_de(lcd_de), .dma0_req(dma0_req),
	.dma0_ack(dma0_ack), .lcd_cls(lcd_cls));

/* lpm_panel_model.sv */
// far side model: pixel clock, frame word source, palette dma channel
`timescale 1ns/1ps
module lpm_panel_model
	import lpm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pix_take,
	input wire logic dma0_req,
	input wire logic slow,
	output logic lcd_pclk_in,
	output logic [31:0] pix_word,
	output logic [7:0] lower_panel_word,
	output logic dma0_ack,
	output logic [31:0] dma0_data,
	output int n_ack
);
	logic [1:0] gap;
	// free running pixel clock, phase unrelated to pclk
	initial
	begin
		lcd_pclk_in = 1'b0;
		#7;
		forever #160 lcd_pclk_in = ~lcd_pclk_in;
	end
	// new word after each take; palette words every 2nd or 4th cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pix_word <= 32'h5AC3_9E61;
			lower_panel_word <= 8'hC6;
			dma0_ack <= 1'b0;
			dma0_data <= 32'h0000_0000;
			n_ack <= 0;
			gap <= 2'd0;
		end
		else
		begin
			gap <= gap + 2'd1;
			if (pix_take)
			begin
				pix_word <= pix_word + 32'h1357_9BDF;
				lower_panel_word <= lower_panel_word + 8'h35;
			end
			if (dma0_req && !dma0_ack && (!slow || gap == 2'd3))
			begin
				dma0_ack <= 1'b1;
				dma0_data <= {n_ack[14:0], 1'b1, n_ack[14:0], 1'b0};
				n_ack <= n_ack + 1;
			end
			else
			begin
				dma0_ack <= 1'b0;
				dma0_data <= ~dma0_data; // no stale data between words
			end
		end
	end
endmodule : lpm_panel_model

/* lpm_pixel_pin_map_tb.sv */
// self-checking bench of the pixel pin map block
`timescale 1ns/1ps
`include "lpm_defs.svh"
module lpm_pixel_pin_map_tb
	import lpm_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, pix_word, dma0_data, q;
	logic [17:0] lcd_dat;
	logic [7:0] lower_panel_word, lcd_alpha;
	logic [5:0] lcd_lo6;
	logic pready, pslverr, lcd_pclk_in, pix_take, dma0_req, dma0_ack, err;
	logic lcd_vsync, lcd_hsync, lcd_de, lcd_pclk_out, lcd_cls, lcd_rev, lcd_spl, pwr_save;
	int n_ack;
	int n_mismatch = 0;
	int comparisons = 0;
	always #20 pclk = ~pclk;
	lpm_pixel_pin_map dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lcd_pclk_in(lcd_pclk_in),
		.pix_word(pix_word), .lower_panel_word(lower_panel_word), .pix_take(pix_take),
		.dma0_req(dma0_req), .dma0_ack(dma0_ack), .dma0_data(dma0_data),
		.lcd_dat(lcd_dat), .lcd_lo6(lcd_lo6), .lcd_alpha(lcd_alpha), .lcd_vsync(lcd_vsync),
		.lcd_hsync(lcd_hsync), .lcd_de(lcd_de), .lcd_pclk_out(lcd_pclk_out),
		.lcd_cls(lcd_cls), .lcd_rev(lcd_rev), .lcd_spl(lcd_spl),
		.power_save_signal(pwr_save));
	lpm_panel_model pm_u (.pclk(pclk), .presetn(presetn), .pix_take(pix_take),
		.dma0_req(dma0_req), .slow(slow), .lcd_pclk_in(lcd_pclk_in), .pix_word(pix_word),
		.lower_panel_word(lower_panel_word), .dma0_ack(dma0_ack), .dma0_data(dma0_data),
		.n_ack(n_ack));
	// compare and report
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer; the bus stays selected for a following one
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		chk(pready, 1'b1);
		q = prdata;
		err = pslverr;
	endtask : apb
	// write and release the bus
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : wr
	// wait for a consumed frame word
	task wait_take();
		int n;
		n = 0;
		do
			@(posedge pclk);
		while (pix_take !== 1'b1 && ++n < 3000);
		chk(pix_take, 1'b1);
	endtask : wait_take
	// idle levels, reset values, back to back access, unmapped address
	task t_regs();
		logic [11:0] offs [4];
		logic [31:0] rst [4];
		offs = '{`LPM_OFF_HTIM, `LPM_OFF_VTIM, `LPM_OFF_SPOS, `LPM_OFF_SPOL};
		rst = '{`LPM_HTIM_RST, `LPM_VTIM_RST, `LPM_SPOS_RST, `LPM_SPOL_RST};
		chk(lcd_hsync, 1'b1);
		chk(lcd_rev, 1'b0);
		foreach (offs[i])
		begin
			apb(1'b0, offs[i], 32'h0000_0000);
			chk(q, rst[i]);
		end
		apb(1'b1, `LPM_OFF_CTRL, 32'h0000_2C0E);
		apb(1'b0, `LPM_OFF_CTRL, 32'h0000_0000);
		chk(q, 32'h0000_2C0E);
		wr(12'h01C, 32'h0000_0000);
		chk({q[30:0], err}, 32'h0000_0001);
	endtask : t_regs
	// sync and pixel clock polarity
	task t_pol();
		int eq;
		logic [2:0] h;
		for (int p = 0; p < 2; p++)
		begin
			wr(`LPM_OFF_CTRL, p ? 32'h0000_0E00 : 32'h0000_0000);
			eq = 0;
			h = 3'b000;
			// output follows the pin three clocks late, inverted when the bit is set
			repeat (67)
			begin
				@(posedge pclk);
				eq += (lcd_pclk_out === (h[2] ^ p[0]));
				h = {h[1:0], lcd_pclk_in};
			end
			chk({lcd_hsync, lcd_vsync, eq > 63}, {!p[0], !p[0], 1'b1});
		end
	endtask : t_pol
	// palette fetch length for every depth, quick channel on even and slow channel on odd depth codes
	task t_pal();
		int words [8];
		int a0, n;
		words = '{1, 2, 8, 128, 0, 0, 0, 0};
		for (int b = 0; b < 8; b++)
		begin
			slow <= b[0];
			wr(`LPM_OFF_CTRL, b << 1);
			a0 = n_ack;
			wr(`LPM_OFF_PLOAD, 32'h0000_0001);
			repeat (2) @(posedge pclk);
			n = 0;
			while (dma0_req === 1'b1 && n++ < 1200) @(posedge pclk);
			chk(n_ack - a0, words[b]);
		end
	endtask : t_pal
	// dual stn pin split per width
	task t_stn();
		logic [17:0] e;
		for (int w = 0; w < 4; w++)
		begin
			wr(`LPM_OFF_CTRL, 32'h0000_0041 | (w << 7));
			wait_take();
			case (w)
				2: e = {6'h00, pix_word[3:0], 4'h0, lower_panel_word[3:0]};
				3: e = {2'b00, pix_word[7:0], lower_panel_word};
				default: e = 18'h0_0000;
			endcase
			chk(lcd_dat, e);
			wr(`LPM_OFF_CTRL, 32'h0000_0000);
		end
	endtask : t_stn
	// tft direct colour layouts and alpha
	task t_tft();
		logic [31:0] w;
		for (int b = 4; b < 8; b++)
		begin
			wr(`LPM_OFF_CTRL, 32'h0000_0021 | (b << 1));
			wait_take();
			w = pix_word;
			if (b == 7)
				chk(lcd_alpha, w[31:24]);
			else if (b == 4)
				chk({lcd_dat[17:13], lcd_dat[11:6], lcd_dat[5:1]}, w[15:0]);
			else
				chk(lcd_dat, {w[23:18], w[15:10], w[7:2]});
			if (b == 6)
				chk(lcd_lo6, {w[17:16], w[9:8], w[1:0]});
			wr(`LPM_OFF_CTRL, 32'h0000_0000);
		end
		// delta panel, first display line is even: blue green red order
		wr(`LPM_OFF_SPOL, 32'h0000_050F);
		wr(`LPM_OFF_CTRL, 32'h0000_402D);
		wait_take();
		w = pix_word;
		chk(lcd_dat, {w[7:2], w[15:10], w[23:18]});
		wr(`LPM_OFF_SPOL, 32'h0000_000F);
		wr(`LPM_OFF_CTRL, 32'h0000_0000);
	endtask : t_tft
	// reversal polarity, then strobes and toggles over four lines
	task t_spec();
		int ncls, nrev, nspl, npwr;
		logic c0, r0, s0, p0;
		wr(`LPM_OFF_SPOL, 32'h0000_000D);
		chk(lcd_rev, 1'b1);
		wr(`LPM_OFF_SPOL, 32'h0000_000F);
		wr(`LPM_OFF_CTRL, 32'h0000_1021);
		ncls = 0;
		nrev = 0;
		nspl = 0;
		npwr = 0;
		repeat (1056)
		begin
			c0 = lcd_cls;
			r0 = lcd_rev;
			s0 = lcd_spl;
			p0 = pwr_save;
			@(posedge pclk);
			ncls += (lcd_cls && !c0);
			nrev += (lcd_rev !== r0);
			nspl += (lcd_spl && !s0);
			npwr += (pwr_save && !p0);
		end
		chk(ncls > 2 && nrev > 2, 1'b1);
		chk(nspl > 2 && npwr > 2, 1'b1);
		wr(`LPM_OFF_CTRL, 32'h0000_0000);
	endtask : t_spec
	// counts and verdict
	task give_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// main sequence
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs();
		t_pol();
		t_pal();
		t_stn();
		t_tft();
		t_spec();
		give_verdict();
	end
	// watchdog
	initial
	begin
		#3_000_000;
		n_mismatch++;
		give_verdict();
	end
endmodule : lpm_pixel_pin_map_tb
